//--- design/pll_buffer_pkg.sv
package pll_buffer_pkg;

  // ----------------------------------------------------------------
  // target addresses on the serial bus (8-bit form, r/w bit included)
  // ----------------------------------------------------------------
  localparam logic [7:0] WRITE_ADDR = 8'hD4;
  localparam logic [7:0] READ_ADDR = 8'hD5;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_DEVICE_CONTROL = 8'h00;
  localparam logic [7:0] REG_OUTPUT_ENABLE_RESERVED = 8'h01;
  localparam logic [7:0] REG_FUNCTION_SELECT_RESERVED = 8'h02;
  localparam logic [7:0] REG_REVISION_VENDOR_IDENT = 8'h03;
  localparam logic [7:0] REG_PART_IDENT = 8'h04;
  localparam logic [7:0] REG_READBACK_LENGTH = 8'h05;

  // ----------------------------------------------------------------
  // device control field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_SOURCE_BIT = 7;
  localparam int CTRL_BANDWIDTH_BIT = 1;
  localparam int CTRL_ZERO_DELAY_BIT = 0;
  localparam logic [7:0] DEVICE_CONTROL_RESET = 8'h83;
  localparam logic [7:0] RESERVED_RESET = 8'h00;
  localparam logic [7:0] READBACK_LENGTH_RESET = 8'h06;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // byte framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_COUNT_FIRST = 4'h1;
  localparam logic [3:0] BIT_COUNT_FULL = 4'h8;

  // ----------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SYNC_WIDTH = 4;
  localparam int LANE_SCL = 0;
  localparam int LANE_SDA = 1;
  localparam int LANE_BW_PIN = 2;
  localparam int LANE_MODE_PIN = 3;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_TACK = 5'h10
  } target_state_t;

  typedef enum logic [3:0] {
    PH_ADDR = 4'h1,
    PH_INDEX = 4'h2,
    PH_COUNT = 4'h4,
    PH_DATA = 4'h8
  } byte_phase_t;

endpackage : pll_buffer_pkg

//--- design/line_sync.sv
`timescale 1ns/1ps
module line_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // ----------------------------------------------------------------
  // two-stage synchroniser, first stage feeds only the second
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta;

  // both stages reset high, the idle level of the bus lines
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta <= '1;
      o_sync <= '1;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule : line_sync

//--- design/pll_buffer_smbus_target.sv
`timescale 1ns/1ps
// Operation
// - host sends start, write address, index; target acks address and index.
// - host sends repeated start and read address; target acks it.
// - first byte sent after read address ack is the byte count.
// - target sends bytes from index upward; host acks all but last.
// - target answers D5 for reads and D4 for writes only.
// - block write carries index, count, data; target acks every byte.
// - control bit 7 picks pins (1) or register bits (0); resets to 1.
// - bit 1 high bandwidth, bit 0 engages loop; both reset to 1.
// - register 5 gives the count byte sent first in a read; resets to six.
// - register 3 holds fixed revision and vendor codes, read only.
// - register 4 holds a fixed part code, read only.
// - reserved bits are plain storage and control nothing.
module pll_buffer_smbus_target #(
  parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
  parameter logic [3:0] VENDOR_CODE = 4'h9, // arbitrary value
  parameter logic [7:0] PART_IDENT_CODE = 8'h5A // arbitrary value
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_smb_clk,
  input wire logic i_smb_data,
  input wire logic i_pll_bw_pin,
  input wire logic i_pll_mode_pin,
  output logic o_smb_data_out,
  output logic o_smb_data_oe,
  output logic o_pll_control_source_select,
  output logic o_pll_bandwidth_select,
  output logic o_zero_delay_mode
);
  import pll_buffer_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and line events
  // ----------------------------------------------------------------
  logic [SYNC_WIDTH-1:0] line_raw;
  logic [SYNC_WIDTH-1:0] line_now;
  logic scl_prev;
  logic sda_prev;

  assign line_raw = {i_pll_mode_pin, i_pll_bw_pin, i_smb_data, i_smb_clk};

  line_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_line_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(line_raw),
    .o_sync(line_now)
  );

  // previous samples for edge detection
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= line_now[LANE_SCL];
      sda_prev <= line_now[LANE_SDA];
    end
  end

  // edges and bus conditions
  wire scl = line_now[LANE_SCL];
  wire sda = line_now[LANE_SDA];
  wire scl_rise = scl & ~scl_prev;
  wire scl_fall = ~scl & scl_prev;
  wire start_det = scl & scl_prev & sda_prev & ~sda;
  wire stop_det = scl & scl_prev & ~sda_prev & sda;

  // ----------------------------------------------------------------
  // state and register storage
  // ----------------------------------------------------------------
  target_state_t state;
  byte_phase_t phase;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] reg_index;
  logic [7:0] write_left;
  logic read_mode;
  logic count_sent;
  logic host_ack;
  logic [7:0] device_control;
  logic [7:0] output_enable_reserved;
  logic [7:0] function_select_reserved;
  logic [7:0] readback_length;

  // register read mux, unmapped indices read as zero
  function automatic logic [7:0] read_reg(input logic [7:0] index);
    logic [7:0] value;
    value = UNMAPPED_READ;
    case (index)
      REG_DEVICE_CONTROL: value = device_control;
      REG_OUTPUT_ENABLE_RESERVED: value = output_enable_reserved;
      REG_FUNCTION_SELECT_RESERVED: value = function_select_reserved;
      REG_REVISION_VENDOR_IDENT: begin
        value = {REVISION_CODE, VENDOR_CODE};
      end
      REG_PART_IDENT: value = PART_IDENT_CODE;
      REG_READBACK_LENGTH: value = readback_length;
      default: value = UNMAPPED_READ;
    endcase
    return value;
  endfunction : read_reg

  // ----------------------------------------------------------------
  // byte decode
  // ----------------------------------------------------------------
  wire byte_full = bit_cnt == BIT_COUNT_FULL;
  wire rx_done = (state == ST_RX) && scl_fall && byte_full;
  wire addr_write_hit = rx_shift == WRITE_ADDR;
  wire addr_read_hit = rx_shift == READ_ADDR;
  wire addr_phase = phase == PH_ADDR;
  // foreign addresses are left unanswered
  wire byte_acked = !addr_phase || addr_write_hit || addr_read_hit;
  wire data_rx = rx_done && (phase == PH_DATA) && !read_mode;
  wire wr_en = data_rx && (write_left != 8'h00);
  wire ack_end = (state == ST_ACK) && scl_fall;
  wire tx_end = (state == ST_TX) && scl_fall;
  wire load_tx = (ack_end && read_mode) ||
                 ((state == ST_TACK) && scl_fall && host_ack);
  // count byte first, then register contents
  wire [7:0] tx_byte = count_sent ? read_reg(reg_index) : readback_length;

  // write strobes; indices 3 and 4 have none
  wire wr_ctrl = wr_en && (reg_index == REG_DEVICE_CONTROL);
  wire wr_rsv1 = wr_en && (reg_index == REG_OUTPUT_ENABLE_RESERVED);
  wire wr_rsv2 = wr_en && (reg_index == REG_FUNCTION_SELECT_RESERVED);
  wire wr_rblen = wr_en && (reg_index == REG_READBACK_LENGTH);

  // ----------------------------------------------------------------
  // bit-level state machine
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= BIT_COUNT_ZERO;
      host_ack <= 1'b0;
    end else if (start_det) begin
      state <= ST_RX;
      bit_cnt <= BIT_COUNT_ZERO;
    end else if (stop_det) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        ST_RX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + BIT_COUNT_FIRST;
          end else if (rx_done) begin
            state <= byte_acked ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state <= read_mode ? ST_TX : ST_RX;
            bit_cnt <= read_mode ? BIT_COUNT_FIRST : BIT_COUNT_ZERO;
          end
        end
        ST_TX: begin
          if (scl_fall && byte_full) begin
            state <= ST_TACK;
          end else if (scl_fall) begin
            bit_cnt <= bit_cnt + BIT_COUNT_FIRST;
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            host_ack <= ~sda;
          end else if (scl_fall) begin
            state <= host_ack ? ST_TX : ST_IDLE;
            bit_cnt <= BIT_COUNT_FIRST;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shift registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
    end else begin
      if ((state == ST_RX) && scl_rise) begin
        rx_shift <= {rx_shift[6:0], sda};
      end
      if (load_tx) begin
        tx_shift <= tx_byte;
      end else if (tx_end && !byte_full) begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // transfer bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      phase <= PH_ADDR;
      reg_index <= 8'h00;
      write_left <= 8'h00;
      read_mode <= 1'b0;
      count_sent <= 1'b0;
    end else if (start_det) begin
      phase <= PH_ADDR; // index kept across repeated start
      read_mode <= 1'b0;
      count_sent <= 1'b0;
    end else if (rx_done) begin
      case (phase)
        PH_ADDR: begin
          read_mode <= addr_read_hit;
          phase <= PH_INDEX;
        end
        PH_INDEX: begin
          reg_index <= rx_shift;
          phase <= PH_COUNT;
        end
        PH_COUNT: begin
          write_left <= rx_shift;
          phase <= PH_DATA;
        end
        PH_DATA: begin
          reg_index <= reg_index + 8'h01;
          if (wr_en) begin
            write_left <= write_left - 8'h01;
          end
        end
        default: begin
          phase <= PH_ADDR;
        end
      endcase
    end else if (load_tx) begin
      count_sent <= 1'b1;
      if (count_sent) begin
        reg_index <= reg_index + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // identity registers are constants, writes to them fall away
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      device_control <= DEVICE_CONTROL_RESET;
      output_enable_reserved <= RESERVED_RESET;
      function_select_reserved <= RESERVED_RESET;
      readback_length <= READBACK_LENGTH_RESET;
    end else begin
      if (wr_ctrl) begin
        device_control <= rx_shift;
      end
      if (wr_rsv1) begin
        output_enable_reserved <= rx_shift;
      end
      if (wr_rsv2) begin
        function_select_reserved <= rx_shift;
      end
      if (wr_rblen) begin
        readback_length <= rx_shift;
      end
    end
  end

  // ----------------------------------------------------------------
  // data line driver, open drain
  // ----------------------------------------------------------------
  // changes only after a clock fall so no false start or stop appears
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_smb_data_oe <= 1'b0;
      o_smb_data_out <= 1'b0;
    end else begin
      o_smb_data_out <= 1'b0;
      if (start_det || stop_det) begin
        o_smb_data_oe <= 1'b0;
      end else if (rx_done) begin
        o_smb_data_oe <= byte_acked;
      end else if (load_tx) begin
        o_smb_data_oe <= ~tx_byte[7];
      end else if (ack_end) begin
        o_smb_data_oe <= 1'b0;
      end else if (tx_end) begin
        o_smb_data_oe <= byte_full ? 1'b0 : ~tx_shift[6];
      end
    end
  end

  // ----------------------------------------------------------------
  // loop control outputs
  // ----------------------------------------------------------------
  wire from_pins = device_control[CTRL_SOURCE_BIT];
  wire next_bandwidth = from_pins ? line_now[LANE_BW_PIN] :
                        device_control[CTRL_BANDWIDTH_BIT];
  wire next_zero_delay = from_pins ? line_now[LANE_MODE_PIN] :
                         device_control[CTRL_ZERO_DELAY_BIT];

  // source select picks pins or register bits
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_pll_control_source_select <= 1'b1;
      o_pll_bandwidth_select <= 1'b1;
      o_zero_delay_mode <= 1'b1;
    end else begin
      o_pll_control_source_select <= from_pins;
      o_pll_bandwidth_select <= next_bandwidth;
      o_zero_delay_mode <= next_zero_delay;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  property p_addr_index_ack;
    rx_done && (phase == PH_INDEX || (addr_phase && addr_write_hit))
      |=> o_smb_data_oe && state == ST_ACK;
  endproperty
  a_addr_index_ack: assert property (p_addr_index_ack)
    else $error("address or index byte not acknowledged");

  property p_read_addr_ack;
    rx_done && addr_phase && addr_read_hit |=> o_smb_data_oe && read_mode;
  endproperty
  a_read_addr_ack: assert property (p_read_addr_ack)
    else $error("read address not acknowledged");

  property p_count_first;
    load_tx && !count_sent |=> tx_shift == $past(readback_length);
  endproperty
  a_count_first: assert property (p_count_first)
    else $error("first read byte is not the byte count");

  property p_ascending;
    load_tx && count_sent |=> reg_index == $past(reg_index) + 8'h01;
  endproperty
  a_ascending: assert property (p_ascending)
    else $error("read index did not step up by one");

  property p_host_nack_ends;
    (state == ST_TACK) && scl_fall && !host_ack && !stop_det
      |=> state == ST_IDLE ##1 !o_smb_data_oe;
  endproperty
  a_host_nack_ends: assert property (p_host_nack_ends)
    else $error("target kept sending after host not-acknowledge");

  property p_foreign_ignored;
    rx_done && addr_phase && !addr_write_hit && !addr_read_hit
      |=> state == ST_IDLE && !o_smb_data_oe;
  endproperty
  a_foreign_ignored: assert property (p_foreign_ignored)
    else $error("foreign address was acknowledged");

  property p_data_ack;
    data_rx |=> o_smb_data_oe [*2];
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("written data byte not acknowledged");

  property p_pin_source;
    from_pins ##1 from_pins |-> o_pll_bandwidth_select ==
      $past(line_now[LANE_BW_PIN]);
  endproperty
  a_pin_source: assert property (p_pin_source)
    else $error("bandwidth not taken from pin");

  property p_reg_source;
    !from_pins ##1 !from_pins |-> o_zero_delay_mode ==
      $past(device_control[CTRL_ZERO_DELAY_BIT]);
  endproperty
  a_reg_source: assert property (p_reg_source)
    else $error("loop mode not taken from register bit");

  property p_length_write;
    wr_rblen |=> readback_length == $past(rx_shift);
  endproperty
  a_length_write: assert property (p_length_write)
    else $error("readback length not written");

  property p_ident_read;
    load_tx && count_sent && reg_index == REG_REVISION_VENDOR_IDENT
      |=> tx_shift == {REVISION_CODE, VENDOR_CODE};
  endproperty
  a_ident_read: assert property (p_ident_read)
    else $error("revision and vendor code wrong");

  property p_part_read;
    load_tx && count_sent && reg_index == REG_PART_IDENT
      |=> tx_shift == PART_IDENT_CODE;
  endproperty
  a_part_read: assert property (p_part_read)
    else $error("part code wrong");

  property p_reserved_store;
    wr_rsv1 |=> output_enable_reserved == $past(rx_shift);
  endproperty
  a_reserved_store: assert property (p_reserved_store)
    else $error("reserved register did not store");

  property p_write_step;
    data_rx |=> reg_index == $past(reg_index) + 8'h01;
  endproperty
  a_write_step: assert property (p_write_step)
    else $error("write index did not step up by one");

  c_block_read: cover property (load_tx && count_sent ##[1:900] stop_det);
  c_block_write: cover property (wr_ctrl);
  c_foreign: cover property (rx_done && addr_phase && !byte_acked);
  c_read_nack: cover property ((state == ST_TACK) && scl_fall && !host_ack);

endmodule : pll_buffer_smbus_target

//--- dv/smbus_host_model.sv
`timescale 1ns/1ps
// ----
// serial host: drives clock and data as open-drain pull-downs
// ----
module smbus_host_model
  import pll_buffer_pkg::*;
#(
  parameter int LOW_NS = 400,
  parameter int HIGH_NS = 400,
  parameter int DATA_NS = 300
) (
  input wire logic i_sda,
  output logic o_scl_low,
  output logic o_sda_low
);
  logic [7:0] wr_buf [0:7];
  logic [7:0] rd_buf [0:7];
  int ack_miss;

  // lines released while no frame runs, clock stands high
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    ack_miss = 0;
  end

  // start or repeated start: data falls while clock high
  task automatic send_start();
    #(DATA_NS) o_sda_low = 1'b0;
    #(LOW_NS - DATA_NS) o_scl_low = 1'b0;
    #(HIGH_NS) o_sda_low = 1'b1;
    #(HIGH_NS) o_scl_low = 1'b1;
  endtask : send_start

  // stop: data rises while clock high
  task automatic send_stop();
    #(DATA_NS) o_sda_low = 1'b1;
    #(LOW_NS - DATA_NS) o_scl_low = 1'b0;
    #(HIGH_NS) o_sda_low = 1'b0;
    #(HIGH_NS);
  endtask : send_stop

  // one byte slot, msb first; nine is the ninth bit driven by the host
  task automatic xfer(input logic [7:0] tx, input logic nine,
      output logic [7:0] rx, output logic ack_bit);
    logic [8:0] sh;
    sh = {tx, nine};
    for (int i = 8; i >= 0; i--) begin
      // data moves late in the low phase, clear of the target's release
      #(DATA_NS) o_sda_low = ~sh[i];
      #(LOW_NS - DATA_NS) o_scl_low = 1'b0;
      if (i > 0) rx[i-1] = i_sda;
      else ack_bit = i_sda;
      #(HIGH_NS) o_scl_low = 1'b1;
    end
  endtask : xfer

  // send a byte, count any missing acknowledge
  task automatic put(input logic [7:0] b);
    logic [7:0] rx;
    logic a;
    xfer(b, 1'b1, rx, a);
    if (a !== 1'b0) ack_miss++;
  endtask : put

  // indexed write: address, index, count, then k data bytes
  task automatic write_block(input logic [7:0] n, input int x, input int k);
    send_start();
    put(WRITE_ADDR);
    put(n);
    put(x[7:0]);
    for (int i = 0; i < k; i++) put(wr_buf[i]);
    send_stop();
  endtask : write_block

  // indexed read: count byte lands in rd_buf[0], data after it
  task automatic read_block(input logic [7:0] n, input int k);
    logic a;
    send_start();
    put(WRITE_ADDR);
    put(n);
    send_start();
    put(READ_ADDR);
    // every byte acked but the last, which gets a not-acknowledge
    for (int i = 0; i <= k; i++) xfer(8'hFF, i == k, rd_buf[i], a);
    send_stop();
  endtask : read_block
endmodule : smbus_host_model

//--- dv/tb_smbus_pll_buffer_control_slave.sv
`timescale 1ns/1ps
module tb_smbus_pll_buffer_control_slave;
  import pll_buffer_pkg::*;
  // ----
  // bench signals
  // ----
  localparam logic [3:0] REV = 4'hC; // arbitrary value
  localparam logic [3:0] VEN = 4'h5; // arbitrary value
  localparam logic [7:0] PART = 8'hB7; // arbitrary value
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_t;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic bw_pin = 1'b0;
  logic mode_pin = 1'b1;
  logic scl_low, sda_low, data_out, data_oe, src_sel, bw_sel, zdm;
  logic [7:0] ctl, cnt;
  logic [7:0] rx;
  logic ack;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  row_t rows [0:5] = '{'{8'h00, 8'h7C, 8'h7C}, '{8'h01, 8'hA5, 8'hA5},
    '{8'h02, 8'h5A, 8'h5A}, '{8'h03, 8'hFF, {REV, VEN}},
    '{8'h04, 8'h00, PART}, '{8'h05, 8'h03, 8'h03}};
  logic [7:0] addrs [0:3] = '{8'hD6, 8'hD0, 8'h54, 8'hD7};
  logic [7:0] rst_val [0:5] = '{8'h83, 8'h00, 8'h00, {REV, VEN}, PART,
    8'h06};
  // open-drain wires with pull-ups
  wire smb_clk = ~scl_low;
  wire smb_data = ~(sda_low | (data_oe & ~data_out));

  // clock and cycle ceiling
  always #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      wrap_up();
    end
  end

  pll_buffer_smbus_target #(
    .REVISION_CODE(REV),
    .VENDOR_CODE(VEN),
    .PART_IDENT_CODE(PART)
  ) i_pll_buffer_smbus_target (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_smb_clk(smb_clk),
    .i_smb_data(smb_data),
    .i_pll_bw_pin(bw_pin),
    .i_pll_mode_pin(mode_pin),
    .o_smb_data_out(data_out),
    .o_smb_data_oe(data_oe),
    .o_pll_control_source_select(src_sel),
    .o_pll_bandwidth_select(bw_sel),
    .o_zero_delay_mode(zdm)
  );

  smbus_host_model i_smbus_host_model (
    .i_sda(smb_data),
    .o_scl_low(scl_low),
    .o_sda_low(sda_low)
  );

  // ----
  // shared tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // control outputs follow pins when bit 7 is set, else bits 1 and 0
  task automatic check_ctl(input logic [7:0] c);
    repeat (8) @(negedge i_mclk);
    check({7'h0, src_sel}, {7'h0, c[7]});
    check({7'h0, bw_sel}, {7'h0, c[7] ? bw_pin : c[1]});
    check({7'h0, zdm}, {7'h0, c[7] ? mode_pin : c[0]});
  endtask : check_ctl

  task automatic wrap_up();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // ----
  // main sequence
  // ----
  initial begin
    repeat (5) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (10) @(negedge i_mclk);
    ctl = DEVICE_CONTROL_RESET;
    cnt = READBACK_LENGTH_RESET;
    // table: write one byte, read it back with the count byte first
    foreach (rows[r]) begin
      i_smbus_host_model.wr_buf[0] = rows[r].wdata;
      i_smbus_host_model.write_block(rows[r].idx, 1, 1);
      if (rows[r].idx == REG_READBACK_LENGTH) cnt = rows[r].wdata;
      if (rows[r].idx == REG_DEVICE_CONTROL) ctl = rows[r].wdata;
      i_smbus_host_model.read_block(rows[r].idx, 1);
      check(i_smbus_host_model.rd_buf[0], cnt);
      check(i_smbus_host_model.rd_buf[1], rows[r].exp);
      check_ctl(ctl);
    end
    $display("table test done");
    // reset in mid-run, then read every register from index 0
    @(negedge i_mclk) i_rst_n = 1'b0;
    repeat (5) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (10) @(negedge i_mclk);
    check_ctl(DEVICE_CONTROL_RESET);
    i_smbus_host_model.read_block(8'h00, 6);
    check(i_smbus_host_model.rd_buf[0], 8'h06);
    for (int i = 0; i < 6; i++) begin
      check(i_smbus_host_model.rd_buf[i+1], rst_val[i]);
    end
    $display("reset test done");
    // two counted bytes plus one beyond the count, then pins take over
    i_smbus_host_model.wr_buf[0] = 8'h02;
    i_smbus_host_model.wr_buf[1] = 8'hC3;
    i_smbus_host_model.wr_buf[2] = 8'h77;
    i_smbus_host_model.write_block(8'h00, 2, 3);
    check_ctl(8'h02);
    @(negedge i_mclk);
    bw_pin = 1'b1;
    mode_pin = 1'b0;
    i_smbus_host_model.wr_buf[0] = 8'h81;
    i_smbus_host_model.write_block(8'h00, 1, 1);
    check_ctl(8'h81);
    i_smbus_host_model.read_block(8'h00, 3);
    check(i_smbus_host_model.rd_buf[1], 8'h81);
    check(i_smbus_host_model.rd_buf[2], 8'hC3);
    check(i_smbus_host_model.rd_buf[3], RESERVED_RESET);
    $display("burst test done");
    // foreign addresses are left unanswered
    foreach (addrs[a]) begin
      i_smbus_host_model.send_start();
      i_smbus_host_model.xfer(addrs[a], 1'b1, rx, ack);
      check({7'h0, ack}, 8'h01);
      i_smbus_host_model.send_stop();
    end
    check(8'(i_smbus_host_model.ack_miss), 8'h00);
    $display("address test done");
    wrap_up();
  end
endmodule : tb_smbus_pll_buffer_control_slave
